// ===== core/pin_sync.sv
`timescale 1ns/100ps
`include "voice_mode_params.svh"
module pin_sync (
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  input  wire logic                     chip_sel_n,
  input  wire logic                     power_down_stop,
  input  wire logic                     marker_seen,
  input  wire logic                     play_rec,
  output voice_mode_pkg::pin_sync_t     synced
);
  // Two sync flops plus an edge-detect flop per pin; stage one is read only by stage two
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic [3:0] prev_reg;

  // Reset to idle pin levels so no false edge or stop level follows reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 4'h9;
      sync_reg <= 4'h9;
      prev_reg <= 4'h9;
    end else begin
      meta_reg <= {chip_sel_n, power_down_stop, marker_seen, play_rec};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign synced.cs  = {prev_reg[3], sync_reg[3]};
  assign synced.pd  = {prev_reg[2], sync_reg[2]};
  assign synced.mk  = {prev_reg[1], sync_reg[1]};
  assign synced.rec = sync_reg[0];
endmodule

// ===== core/voice_mode_ctrl.sv
`timescale 1ns/100ps
`include "voice_mode_params.svh"
// Summary of operation
// - Cue mode: each chip select low pulse skips to the next message, playback only.
// - Merge mode: sequential recordings keep one end marker after the last.
// - Loop mode replays from address zero, wrapping without asserting overflow.
// - Pointer resets past an end marker unless consecutive mode is set.
// - Default: chip select edge-triggered in playback, level-sensitive in record.
// - Level mode: select low plays from zero, stops as soon as select rises.
// - Level mode: new select low restarts at zero unless consecutive mode set.
// - Push mode powers down after each cycle once select is high.
// - Push mode idle: select pulse starts playback or record per play/record.
// - Push mode: further pulse pauses keeping pointer; next pulse resumes.
// - Push mode: stop pulse ends cycle, zeroes pointer, powers down.
// - Push mode: end marker pin is an active-high run indicator.
// - Record pause keeps pointer and writes marker; switch to play starts at zero.
// - Record resume writes after the previous marker and raises run again.
// - With merge mode, resume erases the marker and records from its address.
// - Push recording ended by select or stop leaves an end marker.
// - Push playback pauses at a marker; following record continues there.
// - Push playback in overflow: select low restarts from zero.
// - Push mode: falling select ignored and power-down deferred until debounce.
// - Push mode works together with cue, merge and loop modes.
// - Low address bits are mode bits when both top address bits are high.
// - Mode bits sampled on each accepted falling select and held until the next.
module voice_mode_ctrl #(
  parameter int DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter int POWERUP_CYC  = `POWERUP_CYC,
  parameter int ADDR_W       = `ADDR_W
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              chip_sel_n,
  input  wire logic              power_down_stop,
  input  wire logic              play_rec,
  input  wire logic [8:0]        addr_in,
  input  wire logic              marker_seen,
  input  wire logic              sample_tick,
  output logic                   end_marker_n,
  output logic                   overflow_n,
  output logic                   powered_up,
  output logic                   playing,
  output logic                   recording,
  output logic [ADDR_W-1:0]      msg_addr,
  output logic                   marker_write,
  output logic                   marker_erase
);
  localparam logic [ADDR_W-1:0] LAST = ADDR_W'(`MEM_LAST);
  localparam int CNT_W = 32;

  typedef struct packed {
    voice_mode_pkg::ctrl_state_t state;
    voice_mode_pkg::mode_t       mode;
    logic                        mode_valid;
    logic                        is_rec;
    logic [ADDR_W-1:0]           ptr;
    logic [ADDR_W-1:0]           last_marker;
    logic                        have_marker;
    logic                        ovf;
    logic [CNT_W-1:0]            deb_cnt;
    logic [CNT_W-1:0]            pud_cnt;
    logic                        mk_wr;
    logic                        mk_er;
    logic                        eom_out_n;
    logic                        ovf_out_n;
  } ctrl_t;

  ctrl_t s_reg;
  ctrl_t s_next;
  voice_mode_pkg::pin_sync_t pins;
  logic [8:0] addr_meta_reg;
  logic [8:0] addr_sync_reg;

  pin_sync u_sync (
    .sys_clk         (sys_clk),
    .resetn          (resetn),
    .chip_sel_n      (chip_sel_n),
    .power_down_stop (power_down_stop),
    .marker_seen     (marker_seen),
    .play_rec        (play_rec),
    .synced          (pins)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      addr_meta_reg <= 9'h000;
      addr_sync_reg <= 9'h000;
    end else begin
      addr_meta_reg <= addr_in;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  function automatic logic is_mode_addr(input logic [8:0] a);
    is_mode_addr = a[`TOP_BIT] & a[`SECOND_BIT];
  endfunction

  function automatic voice_mode_pkg::mode_t decode_mode(input logic [8:0] a);
    voice_mode_pkg::mode_t m;
    m.cue    = a[`CUE_BIT];
    m.merge  = a[`MERGE_BIT];
    m.loop   = a[`LOOP_BIT];
    m.consec = a[`CONSEC_BIT];
    m.level  = a[`LEVEL_BIT];
    m.push   = a[`PUSH_BIT];
    decode_mode = m;
  endfunction

  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic pd_rise;
  logic pd_high;
  logic mk_hit;
  logic deb_done;
  logic pud_done;

  always_comb begin
    cs_low   = ~pins.cs[0];
    cs_fall  = pins.cs[1] & ~pins.cs[0];
    cs_rise  = ~pins.cs[1] & pins.cs[0];
    pd_high  = pins.pd[0];
    pd_rise  = ~pins.pd[1] & pins.pd[0];
    mk_hit   = ~pins.mk[1] & pins.mk[0];
    deb_done = (s_reg.deb_cnt >= CNT_W'(DEBOUNCE_CYC));
    pud_done = (s_reg.pud_cnt >= CNT_W'(POWERUP_CYC));
  end

  always_comb begin
    voice_mode_pkg::mode_t m;
    logic accept_fall;
    m = s_reg.mode;
    accept_fall = cs_fall & (deb_done | ~s_reg.mode.push);
    s_next = s_reg;
    s_next.mk_wr = 1'b0;
    s_next.mk_er = 1'b0;
    // Debounce: count select-high time; reset on any low
    if (cs_low)
      s_next.deb_cnt = '0;
    else if (!deb_done)
      s_next.deb_cnt = s_reg.deb_cnt + 1'b1;
    // Mode latch on every accepted falling select
    if (accept_fall) begin
      s_next.mode_valid = is_mode_addr(addr_sync_reg);
      s_next.mode = is_mode_addr(addr_sync_reg) ? decode_mode(addr_sync_reg) : '0;
      m = s_next.mode;
    end

    case (s_reg.state)
      voice_mode_pkg::ST_OFF: begin
        if (accept_fall) begin
          s_next.is_rec  = ~pins.rec;
          s_next.pud_cnt = '0;
          s_next.state   = voice_mode_pkg::ST_POWERUP;
          // Record/playback switch outside push mode returns to zero
          if (!m.push && (~pins.rec != s_reg.is_rec))
            s_next.ptr = '0;
          if (m.level && !(m.consec))
            s_next.ptr = '0;
          if (m.loop || s_reg.ovf) begin
            s_next.ptr = '0;
            s_next.ovf = 1'b0;
          end
          if (m.cue && pins.rec && s_reg.have_marker && !m.push)
            s_next.ptr = s_reg.last_marker + 1'b1;
        end
      end
      voice_mode_pkg::ST_POWERUP: begin
        s_next.pud_cnt = s_reg.pud_cnt + 1'b1;
        if (pud_done)
          s_next.state = voice_mode_pkg::ST_RUN;
        if (!s_reg.is_rec && m.level && !cs_low)
          s_next.state = voice_mode_pkg::ST_OFF;
      end
      voice_mode_pkg::ST_RUN: begin
        if (sample_tick) begin
          if (s_reg.ptr == LAST) begin
            if (m.loop && !s_reg.is_rec) begin
              s_next.ptr = '0;
            end else begin
              s_next.ovf   = 1'b1;
              s_next.state = m.push ? voice_mode_pkg::ST_DRAIN : voice_mode_pkg::ST_OFF;
            end
          end else begin
            s_next.ptr = s_reg.ptr + 1'b1;
          end
        end
        if (!s_reg.is_rec && mk_hit) begin
          s_next.last_marker = s_reg.ptr;
          s_next.have_marker = 1'b1;
          if (m.loop)
            s_next.ptr = '0;
          else if (m.push)
            s_next.state = voice_mode_pkg::ST_PAUSE;
          else begin
            s_next.state = voice_mode_pkg::ST_OFF;
            if (!m.consec)
              s_next.ptr = '0;
          end
        end
        // Default record is level-sensitive; level mode makes playback so too
        if (!m.push && cs_rise && (s_reg.is_rec || m.level)) begin
          s_next.state = voice_mode_pkg::ST_OFF;
          if (s_reg.is_rec) begin
            s_next.mk_wr = 1'b1;
            s_next.last_marker = s_reg.ptr;
            s_next.have_marker = 1'b1;
          end
        end
        if (m.push && accept_fall) begin
          s_next.state = voice_mode_pkg::ST_PAUSE;
          if (s_reg.is_rec) begin
            s_next.mk_wr = 1'b1;
            s_next.last_marker = s_reg.ptr;
            s_next.have_marker = 1'b1;
          end
        end
      end
      voice_mode_pkg::ST_PAUSE: begin
        if (accept_fall) begin
          if (s_reg.is_rec && pins.rec) begin
            s_next.is_rec = 1'b0;
            s_next.ptr    = '0;
          end else begin
            s_next.is_rec = ~pins.rec;
            if (!pins.rec && s_reg.is_rec) begin
              if (m.merge) begin
                s_next.mk_er = 1'b1;
                s_next.ptr   = s_reg.last_marker;
              end else begin
                s_next.ptr   = s_reg.last_marker + 1'b1;
              end
            end
            if (pins.rec && m.cue && s_reg.have_marker)
              s_next.ptr = s_reg.last_marker + 1'b1;
          end
          s_next.state = voice_mode_pkg::ST_RUN;
        end
      end
      voice_mode_pkg::ST_DRAIN: begin
        // Power-down waits for debounced high select
        if (!cs_low && deb_done)
          s_next.state = voice_mode_pkg::ST_OFF;
        if (accept_fall && s_reg.ovf) begin
          s_next.ptr   = '0;
          s_next.ovf   = 1'b0;
          s_next.is_rec = 1'b0;
          s_next.state = voice_mode_pkg::ST_RUN;
        end
      end
      default: s_next.state = voice_mode_pkg::ST_OFF;
    endcase

    if (m.push && pd_rise && s_reg.state != voice_mode_pkg::ST_OFF) begin
      if (s_reg.is_rec && s_reg.state == voice_mode_pkg::ST_RUN)
        s_next.mk_wr = 1'b1;
      s_next.ptr   = '0;
      s_next.ovf   = 1'b0;
      s_next.state = voice_mode_pkg::ST_OFF;
    end else if (!m.push && pd_high) begin
      s_next.ptr   = '0;
      s_next.state = voice_mode_pkg::ST_OFF;
    end

    if (m.push)
      s_next.eom_out_n = (s_next.state == voice_mode_pkg::ST_RUN);
    else
      s_next.eom_out_n = ~(!s_reg.is_rec && mk_hit);
    s_next.ovf_out_n = ~s_next.ovf;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{state: voice_mode_pkg::ST_OFF, default: '0};
      s_reg.eom_out_n <= 1'b1;
      s_reg.ovf_out_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign end_marker_n = s_reg.eom_out_n;
  assign overflow_n   = s_reg.ovf_out_n;
  assign powered_up   = (s_reg.state != voice_mode_pkg::ST_OFF);
  assign playing      = (s_reg.state == voice_mode_pkg::ST_RUN) & ~s_reg.is_rec;
  assign recording    = (s_reg.state == voice_mode_pkg::ST_RUN) & s_reg.is_rec;
  assign msg_addr     = s_reg.ptr;
  assign marker_write = s_reg.mk_wr;
  assign marker_erase = s_reg.mk_er;
endmodule

// ===== inc/voice_mode_params.svh
`ifndef VOICE_MODE_PARAMS_SVH
`define VOICE_MODE_PARAMS_SVH
`define ADDR_W          10
`define MODE_W          7
`define CUE_BIT         0
`define MERGE_BIT       1
`define RESV_BIT        2
`define LOOP_BIT        3
`define CONSEC_BIT      4
`define LEVEL_BIT       5
`define PUSH_BIT        6
`define TOP_BIT         8
`define SECOND_BIT      7
`define CLK_MHZ         250
`define DEBOUNCE_US     100
`define POWERUP_US      25
`define DEBOUNCE_CYC    (`DEBOUNCE_US * `CLK_MHZ)
`define POWERUP_CYC     (`POWERUP_US * `CLK_MHZ)
`define MEM_LAST        10'h3FF
`define ADDR_ZERO       10'h000
`endif

// ===== inc/voice_mode_pkg.sv
package voice_mode_pkg;
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_POWERUP = 3'b001,
    ST_RUN     = 3'b011,
    ST_PAUSE   = 3'b010,
    ST_DRAIN   = 3'b110
  } ctrl_state_t;

  typedef struct packed {
    logic cue;
    logic merge;
    logic loop;
    logic consec;
    logic level;
    logic push;
  } mode_t;

  typedef struct packed {
    logic [1:0] cs;
    logic [1:0] pd;
    logic [1:0] mk;
    logic       rec;
  } pin_sync_t;
endpackage

// ===== verif/button_host.sv
`timescale 1ns/100ps
module button_host (
  input wire logic  sys_clk,
  output logic       chip_sel_n,
  output logic       power_down_stop,
  output logic       play_rec,
  output logic [8:0] addr_in
);
  initial begin
    chip_sel_n = 1'b1;
    power_down_stop = 1'b0;
    play_rec = 1'b1;
    addr_in = 9'h000;
  end
  task automatic set_mode(input logic [6:0] m, input logic pr);
    @(posedge sys_clk);
    addr_in <= {2'b11, m & 7'h7B};
    play_rec <= pr;
  endtask
  // Plain address, no mode decode expected
  task automatic set_addr(input logic [8:0] a, input logic pr);
    @(posedge sys_clk);
    addr_in <= a;
    play_rec <= pr;
  endtask
  task automatic ce_level(input logic v);
    @(posedge sys_clk);
    chip_sel_n <= v;
  endtask
  // Button released long enough to clear debounce before the next press
  task automatic press();
    ce_level(1'b0);
    repeat (3) @(posedge sys_clk);
    chip_sel_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic stop();
    @(posedge sys_clk);
    power_down_stop <= 1'b1;
    repeat (6) @(posedge sys_clk);
    power_down_stop <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
endmodule

// ===== verif/tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin if (sys_clk) @(negedge sys_clk); num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic       sys_clk, resetn, marker_seen, sample_tick, chip_sel_n, power_down_stop, play_rec;
  logic       end_marker_n, overflow_n, powered_up, playing, recording, marker_write, marker_erase;
  logic [8:0] addr_in;
  logic [9:0] msg_addr, exp_addr;
  int         err_total, num_checks, cyc, mw_cnt, me_cnt, n;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  button_host u_button_host (.sys_clk(sys_clk), .chip_sel_n(chip_sel_n), .power_down_stop(power_down_stop),
    .play_rec(play_rec), .addr_in(addr_in));
  voice_mode_ctrl #(.DEBOUNCE_CYC(8), .POWERUP_CYC(4)) u_voice_mode_ctrl (.sys_clk(sys_clk), .resetn(resetn),
    .chip_sel_n(chip_sel_n), .power_down_stop(power_down_stop), .play_rec(play_rec), .addr_in(addr_in),
    .marker_seen(marker_seen), .sample_tick(sample_tick), .end_marker_n(end_marker_n), .overflow_n(overflow_n),
    .powered_up(powered_up), .playing(playing), .recording(recording), .msg_addr(msg_addr),
    .marker_write(marker_write), .marker_erase(marker_erase));
  task test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Run needs about 4700 cycles; ceiling leaves ample margin
  always @(posedge sys_clk) begin
    cyc++;
    if (marker_write === 1'b1) mw_cnt++;
    if (marker_erase === 1'b1) me_cnt++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task tick(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      sample_tick <= 1'b1;
      @(posedge sys_clk);
      sample_tick <= 1'b0;
      exp_addr = exp_addr + 10'h001;
    end
  endtask
  task mark();
    @(posedge sys_clk);
    marker_seen <= 1'b1;
    repeat (3) @(posedge sys_clk);
    marker_seen <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  task halt();
    u_button_host.stop();
    exp_addr = 10'h000;
  endtask
  initial begin
    resetn = 1'b0;
    marker_seen = 1'b0;
    sample_tick = 1'b0;
    exp_addr = 10'h000;
    void'($urandom(56));
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    u_button_host.set_mode(7'h40, 1'b0);
    u_button_host.press();
    `CHK("rec_run", 1'b1, recording)
    `CHK("run_ind", 1'b1, end_marker_n)
    n = 4 + $urandom % 12;
    tick(n);
    `CHK("rec_addr", exp_addr, msg_addr)
    u_button_host.press();
    `CHK("pause_rec", 1'b0, recording)
    `CHK("pause_ind", 1'b0, end_marker_n)
    `CHK("pause_mark", 1, mw_cnt)
    `CHK("pause_addr", exp_addr, msg_addr)
    u_button_host.press();
    exp_addr = exp_addr + 10'h001;
    `CHK("resume_addr", exp_addr, msg_addr)
    `CHK("resume_ind", 1'b1, end_marker_n)
    halt();
    `CHK("stop_addr", exp_addr, msg_addr)
    `CHK("stop_pwr", 1'b0, powered_up)
    `CHK("stop_mark", 2, mw_cnt)
    u_button_host.set_mode(7'h40, 1'b1);
    u_button_host.press();
    `CHK("play_run", 1'b1, playing)
    tick(3);
    mark();
    `CHK("mark_pause", 1'b0, playing)
    `CHK("mark_addr", exp_addr, msg_addr)
    u_button_host.set_mode(7'h40, 1'b0);
    u_button_host.press();
    `CHK("rec_after", 1'b1, recording)
    `CHK("rec_after_addr", exp_addr, msg_addr)
    halt();
    u_button_host.set_mode(7'h42, 1'b0);
    u_button_host.press();
    tick(n);
    u_button_host.press();
    u_button_host.press();
    `CHK("merge_erase", 1, me_cnt)
    `CHK("merge_addr", exp_addr, msg_addr)
    halt();
    // Second fall comes inside the debounce window and must be ignored
    u_button_host.set_mode(7'h40, 1'b0);
    u_button_host.ce_level(1'b0);
    repeat (3) @(posedge sys_clk);
    u_button_host.ce_level(1'b1);
    repeat (2) @(posedge sys_clk);
    u_button_host.press();
    `CHK("bounce_run", 1'b1, recording)
    halt();
    u_button_host.set_mode(7'h48, 1'b1);
    u_button_host.press();
    tick(1030);
    `CHK("loop_ovf", 1'b1, overflow_n)
    `CHK("loop_addr", exp_addr, msg_addr)
    halt();
    u_button_host.set_mode(7'h20, 1'b1);
    u_button_host.ce_level(1'b0);
    repeat (12) @(posedge sys_clk);
    `CHK("lvl_play", 1'b1, playing)
    tick(3);
    u_button_host.ce_level(1'b1);
    repeat (5) @(posedge sys_clk);
    `CHK("lvl_end", 1'b0, playing)
    u_button_host.ce_level(1'b0);
    repeat (12) @(posedge sys_clk);
    `CHK("lvl_restart", 10'h000, msg_addr)
    u_button_host.ce_level(1'b1);
    halt();
    u_button_host.set_mode(7'h30, 1'b1);
    u_button_host.ce_level(1'b0);
    repeat (12) @(posedge sys_clk);
    tick(2);
    u_button_host.ce_level(1'b1);
    repeat (5) @(posedge sys_clk);
    u_button_host.ce_level(1'b0);
    repeat (12) @(posedge sys_clk);
    `CHK("lvl_consec", 10'h002, msg_addr)
    `CHK("lvl_consec_run", 1'b1, playing)
    u_button_host.ce_level(1'b1);
    halt();
    // Last stored marker sits at n, so cueing lands just past it
    u_button_host.set_mode(7'h01, 1'b1);
    u_button_host.press();
    exp_addr = 10'(n + 1);
    `CHK("cue_addr", exp_addr, msg_addr)
    `CHK("edge_play", 1'b1, playing)
    mark();
    `CHK("eom_reset", 10'h000, msg_addr)
    `CHK("eom_stop", 1'b0, playing)
    // Bit six set without both top bits must not select push mode
    u_button_host.set_addr(9'h055, 1'b0);
    u_button_host.ce_level(1'b0);
    repeat (12) @(posedge sys_clk);
    `CHK("plain_rec", 1'b1, recording)
    u_button_host.ce_level(1'b1);
    repeat (5) @(posedge sys_clk);
    `CHK("plain_rec_end", 1'b0, recording)
    halt();
    u_button_host.set_mode(7'h40, 1'b1);
    u_button_host.press();
    tick(1024);
    `CHK("ovf_set", 1'b0, overflow_n)
    `CHK("ovf_addr", 10'h3FF, msg_addr)
    repeat (3) @(posedge sys_clk);
    `CHK("ovf_off", 1'b0, powered_up)
    u_button_host.press();
    `CHK("ovf_restart", 10'h000, msg_addr)
    `CHK("ovf_play", 1'b1, playing)
    `CHK("ovf_clear", 1'b1, overflow_n)
    halt();
    test_done();
  end
endmodule

// ===== verif/voice_mode_ctrl_properties.sv
`timescale 1ns/100ps
module voice_mode_props #(
  parameter int ADDR_W = 10
) (
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic              power_down_stop,
  input wire logic              sample_tick,
  input wire logic              overflow_n,
  input wire logic              powered_up,
  input wire logic              playing,
  input wire logic              recording,
  input wire logic [ADDR_W-1:0] msg_addr,
  input wire logic              marker_write
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence stop_held; power_down_stop [*6]; endsequence
  sequence wake; $rose(powered_up); endsequence
  sequence rec_step; recording && sample_tick && msg_addr != '1 ##1 recording; endsequence
  idle_off_a: assert property (!powered_up |-> !playing && !recording)
    else $error("operation while powered off");
  one_op_a: assert property (!(playing && recording))
    else $error("play and record together");
  write_pulse_a: assert property (marker_write |=> !marker_write)
    else $error("marker write longer than one cycle");
  write_src_a: assert property (marker_write |-> $past(recording))
    else $error("marker write outside recording");
  stop_zero_a: assert property (stop_held |-> msg_addr == '0 && !playing && !recording)
    else $error("stop did not clear pointer");
  rec_advance_a: assert property (rec_step |-> msg_addr == $past(msg_addr) + 1'b1)
    else $error("pointer did not advance");
  ovf_end_a: assert property ($fell(overflow_n) |-> $past(msg_addr) == '1)
    else $error("overflow before last address");
  powerup_wait_a: assert property (wake |-> !(playing || recording) [*4])
    else $error("operation before power-up delay");
endmodule
bind voice_mode_ctrl voice_mode_props #(.ADDR_W(ADDR_W)) u_props (
  .sys_clk(sys_clk), .resetn(resetn), .power_down_stop(power_down_stop), .sample_tick(sample_tick),
  .overflow_n(overflow_n), .powered_up(powered_up), .playing(playing), .recording(recording),
  .msg_addr(msg_addr), .marker_write(marker_write));
